// ===== charger_ctrl_regs.sv
`timescale 1ns/100ps
// Operation
// - Kick write restarts watchdog, bit self-clears
// - Period code zero disables, else selects timeout
// - Force bit starts detection, clears when done
// - Auto enable runs detection on plug-in
// - Separate enables allow 12 V, 9 V
// - HV port enable gates adapter handshake
// - Ship field requests idle/shutdown/ship/reset
// - Delay bit zero waits 10 s first
// - Override forces both gate enables low
// - Light-load disable bit blocks forward PFM
// - Wake pin low 1 s or 15 ms
// - Linear disable stops pre-charge LDO mode
// - Out-of-audio disable bit turns mode off
// - Each gate enable drives one FET pair
// - Ship field locked zero until FET fitted
module charger_ctrl_regs
    import charger_ctrl_pkg::*;
#(
    parameter int HALF_SEC = HALF_SEC_CYCLES,
    parameter int WAKE_SHORT = WAKE_SHORT_CYCLES
) (
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       reg_reset_in,
    input  wire logic       ship_fet_fitted_in,
    input  wire logic       vbus_plugin_in,
    input  wire logic       detect_done_in,
    input  wire logic       input_gate_drive_one_enable_in,
    input  wire logic       input_gate_drive_two_enable_in,
    input  wire logic       wake_pin_in,
    output logic            detect_start_out,
    output logic            watchdog_expired_out,
    output logic            ship_action_out,
    output logic      [1:0] ship_action_mode_out,
    output logic            ship_wake_out,
    output logic            input_gate_drive_one_out,
    output logic            input_gate_drive_two_out,
    output ctrl_cfg_s       cfg_out
);

    // ****************************************
    // Reset release and pin synchroniser
    // ****************************************
    logic       rst_meta_q;
    logic       rst_n_q;
    logic [1:0] wake_sync_q;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_q  <= 1'b0;
            rst_n_q     <= 1'b0;
            wake_sync_q <= 2'b11;
        end else begin
            rst_meta_q  <= 1'b1;
            rst_n_q     <= rst_meta_q;
            wake_sync_q <= {wake_sync_q[0], wake_pin_in};
        end
    end

    function automatic logic [31:0] wd_limit(input logic [2:0] code);
        logic [31:0] halves;
        halves = 32'h0;
        case (code)
            3'h1:    halves = 32'h1;
            3'h2:    halves = 32'h2;
            3'h3:    halves = 32'h4;
            3'h4:    halves = 32'h28;
            3'h5:    halves = 32'h50;
            3'h6:    halves = 32'hA0;
            3'h7:    halves = 32'h140;
            default: halves = 32'h0;
        endcase
        wd_limit = 32'(halves * 32'(HALF_SEC));
    endfunction

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0]  one_q, one_d, two_q, two_d, three_q, three_d;
    logic [31:0] wd_cnt_q, wd_cnt_d, ship_cnt_q, ship_cnt_d, wake_cnt_q, wake_cnt_d;
    logic        ship_pend_q, ship_pend_d, ship_active_q, ship_active_d;
    logic        det_start_q, det_start_d, wd_exp_q, wd_exp_d;
    logic        act_q, act_d, wake_q, wake_d;
    logic [1:0]  act_mode_q, act_mode_d;

    logic        wr_one, wr_two, wr_three, wd_expire;
    logic [31:0] wd_lim, wake_lim;

    always_comb begin
        wr_one    = reg_write_in && reg_addr_in == CTRL_ONE_OFFSET;
        wr_two    = reg_write_in && reg_addr_in == CTRL_TWO_OFFSET;
        wr_three  = reg_write_in && reg_addr_in == CTRL_THREE_OFFSET;
        wd_lim    = wd_limit(one_q[WD_PERIOD_LSB +: 3]);
        wd_expire = wd_lim != 32'h0 && wd_cnt_q >= wd_lim - 32'h1;
        wake_lim  = three_q[WAKE_HOLD_BIT] ? 32'(WAKE_SHORT)
                                           : 32'(WAKE_LONG_HALVES * HALF_SEC);
        one_d         = one_q;
        two_d         = two_q;
        three_d       = three_q;
        wd_cnt_d      = wd_cnt_q + 32'h1;
        ship_cnt_d    = ship_cnt_q;
        ship_pend_d   = ship_pend_q;
        ship_active_d = ship_active_q;
        wake_cnt_d    = 32'h0;
        det_start_d   = 1'b0;
        wd_exp_d      = 1'b0;
        act_d         = 1'b0;
        act_mode_d    = act_mode_q;
        wake_d        = 1'b0;

        // Self-clearing kick restarts the timer
        if (one_q[KICK_BIT] || wd_lim == 32'h0) begin
            wd_cnt_d        = 32'h0;
            one_d[KICK_BIT] = 1'b0;
        end
        if (detect_done_in) begin
            two_d[FORCE_DET_BIT] = 1'b0;
        end
        if (wd_expire) begin
            wd_cnt_d                  = 32'h0;
            wd_exp_d                  = 1'b1;
            one_d[KICK_BIT]           = 1'b0;
            two_d[FORCE_DET_BIT]      = 1'b0;
            two_d[AUTO_DET_BIT]       = CTRL_TWO_RESET[AUTO_DET_BIT];
            three_d[LDO_DIS_BIT]      = CTRL_THREE_RESET[LDO_DIS_BIT];
        end

        // Writes; reserved bits masked off
        if (wr_one) begin
            one_d = reg_wdata_in & 8'h3F;
        end
        if (wr_two) begin
            two_d[7:3]          = reg_wdata_in[7:3];
            two_d[SHIP_DLY_BIT] = reg_wdata_in[SHIP_DLY_BIT];
            // Field only writable with a ship FET present
            if (ship_fet_fitted_in) begin
                two_d[SHIP_REQ_LSB +: 2] = reg_wdata_in[SHIP_REQ_LSB +: 2];
                ship_pend_d = reg_wdata_in[SHIP_REQ_LSB +: 2] != 2'(SHIP_IDLE);
                ship_cnt_d  = 32'h0;
            end
            if (reg_wdata_in[FORCE_DET_BIT]) begin
                det_start_d = 1'b1;
            end
        end
        if (wr_three) begin
            three_d = reg_wdata_in & 8'h9D;
        end
        if (vbus_plugin_in && two_q[AUTO_DET_BIT]) begin
            det_start_d = 1'b1;
        end

        // Ship FET action, with or without the long delay
        if (ship_pend_q && !(wr_two && ship_fet_fitted_in)) begin
            ship_cnt_d = ship_cnt_q + 32'h1;
            if (two_q[SHIP_DLY_BIT] ||
                ship_cnt_q >= 32'(SHIP_DELAY_HALVES * HALF_SEC) - 32'h1) begin
                ship_pend_d   = 1'b0;
                act_d         = 1'b1;
                act_mode_d    = two_q[SHIP_REQ_LSB +: 2];
                ship_active_d = two_q[SHIP_REQ_LSB +: 2] == 2'(SHIP_SHIP);
            end
        end

        // Wake from ship mode needs an unbroken low hold
        if (ship_active_q && !wake_sync_q[1]) begin
            wake_cnt_d = wake_cnt_q + 32'h1;
            if (wake_cnt_q >= wake_lim - 32'h1) begin
                wake_d        = 1'b1;
                ship_active_d = 1'b0;
                wake_cnt_d    = 32'h0;
            end
        end

        if (!ship_fet_fitted_in) begin
            two_d[SHIP_REQ_LSB +: 2] = 2'(SHIP_IDLE);
            ship_pend_d = 1'b0;
        end
        if (reg_reset_in) begin
            one_d         = CTRL_ONE_RESET;
            two_d         = CTRL_TWO_RESET;
            three_d       = CTRL_THREE_RESET;
            wd_cnt_d      = 32'h0;
            ship_pend_d   = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            one_q         <= CTRL_ONE_RESET;
            two_q         <= CTRL_TWO_RESET;
            three_q       <= CTRL_THREE_RESET;
            wd_cnt_q      <= 32'h0;
            ship_cnt_q    <= 32'h0;
            wake_cnt_q    <= 32'h0;
            ship_pend_q   <= 1'b0;
            ship_active_q <= 1'b0;
            det_start_q   <= 1'b0;
            wd_exp_q      <= 1'b0;
            act_q         <= 1'b0;
            act_mode_q    <= 2'h0;
            wake_q        <= 1'b0;
        end else begin
            one_q         <= one_d;
            two_q         <= two_d;
            three_q       <= three_d;
            wd_cnt_q      <= wd_cnt_d;
            ship_cnt_q    <= ship_cnt_d;
            wake_cnt_q    <= wake_cnt_d;
            ship_pend_q   <= ship_pend_d;
            ship_active_q <= ship_active_d;
            det_start_q   <= det_start_d;
            wd_exp_q      <= wd_exp_d;
            act_q         <= act_d;
            act_mode_q    <= act_mode_d;
            wake_q        <= wake_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_comb begin
        case (reg_addr_in)
            CTRL_ONE_OFFSET:   reg_rdata_out = one_q;
            CTRL_TWO_OFFSET:   reg_rdata_out = two_q;
            CTRL_THREE_OFFSET: reg_rdata_out = three_q;
            default:           reg_rdata_out = 8'h00;
        endcase
    end

    // Override acts on the live enables, so clearing it restores host values
    assign input_gate_drive_one_out = input_gate_drive_one_enable_in &&
                                      !three_q[GATE_OVR_BIT];
    assign input_gate_drive_two_out = input_gate_drive_two_enable_in &&
                                      !three_q[GATE_OVR_BIT];
    assign detect_start_out     = det_start_q;
    assign watchdog_expired_out = wd_exp_q;
    assign ship_action_out      = act_q;
    assign ship_action_mode_out = act_mode_q;
    assign ship_wake_out        = wake_q;

    assign cfg_out.input_overvoltage_threshold  = one_q[OVP_LSB +: 2];
    assign cfg_out.watchdog_period              = one_q[WD_PERIOD_LSB +: 3];
    assign cfg_out.allow_twelve_volt_request    = two_q[TWELVE_BIT];
    assign cfg_out.allow_nine_volt_request      = two_q[NINE_BIT];
    assign cfg_out.high_voltage_port_enable     = two_q[HVDCP_BIT];
    assign cfg_out.forward_light_load_disable   = three_q[PFM_DIS_BIT];
    assign cfg_out.ship_wake_hold_time          = three_q[WAKE_HOLD_BIT];
    assign cfg_out.precharge_linear_disable     = three_q[LDO_DIS_BIT];
    assign cfg_out.forward_out_of_audio_disable = three_q[OOA_DIS_BIT];

endmodule // charger_ctrl_regs

// ===== charger_ctrl_pkg.sv
package charger_ctrl_pkg;

    // ****************************************
    // Register offsets and reset values
    // ****************************************
    localparam logic [7:0] CTRL_ONE_OFFSET   = 8'h10;
    localparam logic [7:0] CTRL_TWO_OFFSET   = 8'h11;
    localparam logic [7:0] CTRL_THREE_OFFSET = 8'h12;
    localparam logic [7:0] CTRL_ONE_RESET    = 8'h35;
    localparam logic [7:0] CTRL_TWO_RESET    = 8'h40;
    localparam logic [7:0] CTRL_THREE_RESET  = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int OVP_LSB       = 4;
    localparam int KICK_BIT      = 3;
    localparam int WD_PERIOD_LSB = 0;
    localparam int FORCE_DET_BIT = 7;
    localparam int AUTO_DET_BIT  = 6;
    localparam int TWELVE_BIT    = 5;
    localparam int NINE_BIT      = 4;
    localparam int HVDCP_BIT     = 3;
    localparam int SHIP_REQ_LSB  = 1;
    localparam int SHIP_DLY_BIT  = 0;
    localparam int GATE_OVR_BIT  = 7;
    localparam int PFM_DIS_BIT   = 4;
    localparam int WAKE_HOLD_BIT = 3;
    localparam int LDO_DIS_BIT   = 2;
    localparam int OOA_DIS_BIT   = 0;

    // ****************************************
    // Timing: base unit half a second; long delays in whole multiples of it, short wake hold in clock cycles
    // ****************************************
    localparam int  CLK_HZ            = 20_000_000;
    localparam int  HALF_SEC_MS       = 500;
    localparam int  HALF_SEC_CYCLES   = CLK_HZ / 1000 * HALF_SEC_MS;
    localparam int  SHIP_DELAY_S      = 10;
    localparam int  SHIP_DELAY_HALVES = SHIP_DELAY_S * 2;
    localparam int  WAKE_LONG_S       = 1;
    localparam int  WAKE_LONG_HALVES  = WAKE_LONG_S * 2;
    localparam int  WAKE_SHORT_MS     = 15;
    localparam int  WAKE_SHORT_CYCLES = CLK_HZ / 1000 * WAKE_SHORT_MS;

    // ****************************************
    // Codes
    // ****************************************
    typedef enum logic [1:0] {
        SHIP_IDLE,
        SHIP_SHUTDOWN,
        SHIP_SHIP,
        SHIP_POWER_RESET
    } ship_mode_e;

    typedef struct packed {
        logic [1:0] input_overvoltage_threshold;
        logic [2:0] watchdog_period;
        logic       allow_twelve_volt_request;
        logic       allow_nine_volt_request;
        logic       high_voltage_port_enable;
        logic       forward_light_load_disable;
        logic       ship_wake_hold_time;
        logic       precharge_linear_disable;
        logic       forward_out_of_audio_disable;
    } ctrl_cfg_s;

endpackage

// ===== charger_ctrl_regs_sva.sv
`timescale 1ns/100ps
module charger_ctrl_regs_chk
    import charger_ctrl_pkg::*;
(
    input wire logic       mclk_in,
    input wire logic       reset_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_write_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       reg_reset_in,
    input wire logic       ship_fet_fitted_in,
    input wire logic       input_gate_drive_one_enable_in,
    input wire logic       input_gate_drive_two_enable_in,
    input wire logic       detect_start_out,
    input wire logic       watchdog_expired_out,
    input wire logic       ship_action_out,
    input wire logic [1:0] ship_action_mode_out,
    input wire logic       input_gate_drive_one_out,
    input wire logic       input_gate_drive_two_out,
    input wire ctrl_cfg_s  cfg_out
);
    // ****
    // Properties
    // ****
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_wr(a);
        reg_write_in && !reg_reset_in && reg_addr_in == a;
    endsequence
    property p_gate_one;
        reg_addr_in == 8'h12 |-> input_gate_drive_one_out ==
            (input_gate_drive_one_enable_in && !reg_rdata_out[7]);
    endproperty
    property p_gate_two;
        reg_addr_in == 8'h12 |-> input_gate_drive_two_out ==
            (input_gate_drive_two_enable_in && !reg_rdata_out[7]);
    endproperty
    property p_resv_one;
        reg_addr_in == 8'h10 |-> reg_rdata_out[7:6] == 2'b00;
    endproperty
    property p_resv_three;
        reg_addr_in == 8'h12 |-> {reg_rdata_out[6:5], reg_rdata_out[1]} == 3'b000;
    endproperty
    property p_force;
        s_wr(8'h11) ##0 (reg_wdata_in[7] && !reg_rdata_out[7]) |=> detect_start_out;
    endproperty
    // Kick may be re-armed by a new write, so only idle cycles are judged
    property p_kick;
        reg_addr_in == 8'h10 && reg_rdata_out[3] && !reg_write_in
            |=> reg_addr_in != 8'h10 || !reg_rdata_out[3];
    endproperty
    property p_lock;
        !ship_fet_fitted_in && reg_addr_in == 8'h11 |-> reg_rdata_out[2:1] == 2'b00;
    endproperty
    property p_fast;
        s_wr(8'h11) ##0 (ship_fet_fitted_in && reg_wdata_in[0] && reg_wdata_in[2:1] != 2'b00)
            ##1 (!reg_write_in && !reg_reset_in)
            |=> ship_action_out && ship_action_mode_out == $past(reg_wdata_in[2:1], 2);
    endproperty
    property p_slow;
        s_wr(8'h11) ##0 (ship_fet_fitted_in && !reg_wdata_in[0] && reg_wdata_in[2:1] != 2'b00)
            |=> !ship_action_out [*8];
    endproperty
    property p_cfg;
        s_wr(8'h12) |=> cfg_out.forward_light_load_disable == $past(reg_wdata_in[4])
            && cfg_out.ship_wake_hold_time == $past(reg_wdata_in[3])
            && cfg_out.forward_out_of_audio_disable == $past(reg_wdata_in[0]);
    endproperty
    property p_regrst;
        reg_reset_in |=> cfg_out == 12'hE80;
    endproperty
    property p_wd_off;
        watchdog_expired_out |-> cfg_out.watchdog_period != 3'h0;
    endproperty
    a_gate_one: assert property (p_gate_one) else $error("gate one wrong");
    a_gate_two: assert property (p_gate_two) else $error("gate two wrong");
    a_resv_one: assert property (p_resv_one) else $error("reserved bits set");
    a_resv_three: assert property (p_resv_three) else $error("reserved bits set");
    a_force: assert property (p_force) else $error("no detect start");
    a_kick: assert property (p_kick) else $error("kick stuck");
    a_lock: assert property (p_lock) else $error("ship field unlocked");
    a_fast: assert property (p_fast) else $error("ship action missing");
    a_slow: assert property (p_slow) else $error("ship action early");
    a_cfg: assert property (p_cfg) else $error("cfg copy wrong");
    a_regrst: assert property (p_regrst) else $error("reset values wrong");
    a_wd_off: assert property (p_wd_off) else $error("disabled timer fired");
endmodule // charger_ctrl_regs_chk

bind charger_ctrl_regs charger_ctrl_regs_chk u_chk (.mclk_in, .reset_n_in, .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .reg_rdata_out, .reg_reset_in, .ship_fet_fitted_in,
    .input_gate_drive_one_enable_in, .input_gate_drive_two_enable_in, .detect_start_out,
    .watchdog_expired_out, .ship_action_out, .ship_action_mode_out,
    .input_gate_drive_one_out, .input_gate_drive_two_out, .cfg_out);

// ===== host_model.sv
`timescale 1ns/100ps
// ****
// Host byte port
// ****
module host_model (
    input  wire logic       mclk_in,
    input  wire logic [7:0] rdata_in,
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            write_out
);
    initial begin
        addr_out  = 8'h00;
        wdata_out = 8'h00;
        write_out = 1'b0;
    end
    // Released data is inverted so a stale byte never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        addr_out  = a;
        wdata_out = d;
        write_out = 1'b1;
        @(negedge mclk_in);
        write_out = 1'b0;
        wdata_out = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge mclk_in);
        addr_out = a;
        #1 v = rdata_in;
    endtask
endmodule // host_model

// ===== charger_control_regs_1_to_3_tb.sv
`timescale 1ns/100ps
module charger_control_regs_1_to_3_tb
    import charger_ctrl_pkg::*;
;
    logic       mclk_in, reset_n_in, reg_reset_in, fit, plug, done, en1, en2, wake;
    logic       wr, det, wdx, act, wk, g1, g2, hit;
    logic [7:0] addr, wdata, rdata, v, d;
    logic [1:0] mode;
    logic [31:0] seed = 32'h18F3C495;
    ctrl_cfg_s  cfg;
    int         bad_count, n_tests, n;
    host_model h (.mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
        .write_out(wr));
    charger_ctrl_regs #(.HALF_SEC(20), .WAKE_SHORT(5)) dut (.mclk_in(mclk_in),
        .reset_n_in(reset_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
        .reg_rdata_out(rdata), .reg_reset_in(reg_reset_in), .ship_fet_fitted_in(fit),
        .vbus_plugin_in(plug), .detect_done_in(done), .input_gate_drive_one_enable_in(en1),
        .input_gate_drive_two_enable_in(en2), .wake_pin_in(wake), .detect_start_out(det),
        .watchdog_expired_out(wdx), .ship_action_out(act), .ship_action_mode_out(mode),
        .ship_wake_out(wk), .input_gate_drive_one_out(g1), .input_gate_drive_two_out(g2),
        .cfg_out(cfg));
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Read-back mask: kick clears itself, force waits for detection, ship field needs the FET
    function automatic logic [7:0] exp_rd(int a, logic [7:0] x);
        case (a)
            0: return x & 8'h37;
            1: return x & (fit ? 8'hFF : 8'hF9);
            default: return x & 8'h9D;
        endcase
    endfunction
    function automatic logic sig(int s);
        case (s)
            0: return det;
            1: return act;
            2: return wk;
            default: return wdx;
        endcase
    endfunction
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(int s, int lim, output int c, output logic f);
        c = 0;
        f = sig(s);
        while (f !== 1'b1 && c < lim) begin
            @(posedge mclk_in);
            #1 c++;
            f = sig(s);
        end
    endtask
    task automatic pulse(input int s);
        @(negedge mclk_in);
        if (s == 0) plug = 1'b1; else if (s == 1) done = 1'b1; else reg_reset_in = 1'b1;
        @(negedge mclk_in);
        {plug, done, reg_reset_in} = 3'b000;
    endtask
    task automatic chk_defaults();
        for (int a = 0; a < 3; a++) begin
            h.rd(8'h10 + a[7:0], v);
            chk("default", a == 0 ? 8'h35 : (a == 1 ? 8'h40 : 8'h00), v);
        end
        h.rd(8'h13, v);
        chk("unmapped", 8'h00, v);
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    initial begin
        #200000 bad_count++;
        print_verdict();
    end
    // ****
    // Scenarios
    // ****
    initial begin
        {reset_n_in, reg_reset_in, fit, plug, done, en1, en2} = 7'h00;
        wake = 1'b1;
        repeat (16) @(negedge mclk_in);
        reset_n_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        chk_defaults();
        h.wr(8'h10, 8'h37);
        repeat (12) begin
            for (int a = 0; a < 3; a++) begin
                d = 8'(rnd());
                if (a == 0) d[2] = 1'b1;
                h.wr(8'h10 + a[7:0], d);
                h.rd(8'h10 + a[7:0], v);
                chk("readback", exp_rd(a, d), v);
                if (a == 0) chk("ovp", {6'h00, d[5:4]}, {6'h00, cfg.input_overvoltage_threshold});
                if (a == 0) chk("period", {5'h00, d[2:0]}, {5'h00, cfg.watchdog_period});
                // Packed order: twelve, nine, port enable, then light-load, wake, linear, audio
                if (a == 1) chk("hv", {5'h00, d[5:3]}, {5'h00, cfg[6:4]});
                if (a == 2) chk("cfg3", {4'h0, d[4:2], d[0]}, {4'h0, cfg[3:0]});
            end
            @(negedge mclk_in) {en1, en2} = 2'(rnd());
            #1 chk("gates", {6'h00, en1 & ~d[7], en2 & ~d[7]}, {6'h00, g1, g2});
        end
        pulse(1);
        h.wr(8'h11, 8'hC0);
        chk("start", 8'h01, {7'h00, det});
        h.rd(8'h11, v);
        chk("force set", 8'hC0, v);
        pulse(1);
        h.rd(8'h11, v);
        chk("force clr", 8'h40, v);
        pulse(0);
        wt(0, 4, n, hit);
        chk("auto on", 8'h01, {7'h00, hit});
        h.wr(8'h11, 8'h00);
        pulse(0);
        wt(0, 4, n, hit);
        chk("auto off", 8'h00, {7'h00, hit});
        @(negedge mclk_in) fit = 1'b1;
        for (int m = 1; m < 4; m++) begin
            h.wr(8'h11, {5'h00, m[1:0], 1'b1});
            wt(1, 3, n, hit);
            chk("action", {6'h00, m[1:0]}, {6'h00, hit ? mode : 2'b00});
        end
        h.wr(8'h11, 8'h05);
        wt(1, 3, n, hit);
        h.wr(8'h12, 8'h08);
        @(negedge mclk_in) wake = 1'b0;
        wt(2, 20, n, hit);
        chk("wake", 8'h01, {7'h00, hit && n >= 5});
        @(negedge mclk_in) wake = 1'b1;
        h.wr(8'h11, 8'h02);
        wt(1, 450, n, hit);
        chk("delay", 8'h01, {7'h00, hit && n >= 390 && n <= 410});
        // Kick first so the shortest period counts from a known start
        h.wr(8'h10, 8'h3F);
        h.wr(8'h10, 8'h31);
        wt(3, 60, n, hit);
        chk("expiry", 8'h01, {7'h00, hit && n >= 15 && n <= 25});
        h.rd(8'h11, v);
        h.wr(8'h10, 8'h30);
        chk("wd defaults", 8'h42, v);
        wt(3, 100, n, hit);
        chk("wd off", 8'h00, {7'h00, hit});
        pulse(2);
        chk_defaults();
        print_verdict();
    end
endmodule // charger_control_regs_1_to_3_tb
